//--- inc/oss_pkg.sv
// Package: constants and types for the strap startup control block
package oss_pkg;

    // Clock rate and time base
    localparam int unsigned OSS_CLK_HZ = 25_000_000;
    localparam int unsigned OSS_DELAY_STEP_S = 12;
    // Cycles in one second; the divider terminal count is one less
    localparam int unsigned OSS_SEC_CYCLES = OSS_CLK_HZ;
    localparam int unsigned OSS_SEC_CNT_W = 25;
    localparam logic [OSS_SEC_CNT_W-1:0] OSS_SEC_LAST =
        OSS_SEC_CNT_W'(OSS_SEC_CYCLES - 1);

    // SCSI ID width (wide bus, 16 targets)
    localparam int unsigned OSS_ID_W = 4;
    // Delay in seconds fits ID*12 = 180 max
    localparam int unsigned OSS_DSEC_W = 8;
    localparam logic [OSS_DSEC_W-1:0] OSS_STEP = 8'h0C;
    localparam logic [OSS_DSEC_W-1:0] OSS_DSEC_ZERO = 8'h00;
    localparam logic [OSS_SEC_CNT_W-1:0] OSS_SEC_ZERO = 25'h000_0000;

    // Captured strap set
    typedef struct packed {
        logic force_single_ended_strap;
        logic delayed_spinup_strap;
        logic await_start_command_strap;
        logic write_protect_strap;
        logic parity_disable_strap;
        logic [OSS_ID_W-1:0] scsi_id;
    } oss_straps_s;

    localparam oss_straps_s OSS_STRAPS_RESET = '0;

    // Spindle sequencing states
    typedef enum logic [1:0] {
        OSS_CAPTURE,
        OSS_WAIT_CMD,
        OSS_DELAY,
        OSS_RUN
    } oss_state_e;

endpackage : oss_pkg

//--- rtl/oss_sec_tick.sv
// One-second enable pulse divider for the strap startup control block
`timescale 1ns/1ps
`default_nettype none
module oss_sec_tick
    import oss_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Control
    input wire logic run_in,
    // Output
    output logic tick_out
);

    logic [OSS_SEC_CNT_W-1:0] count; // Cycles within the current second

    // Count while enabled; restart from zero whenever stopped
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count <= OSS_SEC_ZERO;
        end else if (!run_in || count == OSS_SEC_LAST) begin
            count <= OSS_SEC_ZERO;
        end else begin
            count <= count + 1'b1;
        end
    end

    // Pulse on the last cycle of each full second
    assign tick_out = run_in && (count == OSS_SEC_LAST);

endmodule : oss_sec_tick
`default_nettype wire

//--- rtl/oss_startup_ctrl.sv
// Strap capture, spindle start sequencing and option control for the drive
`timescale 1ns/1ps
`default_nettype none
module oss_startup_ctrl
    import oss_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Jumper straps and drive ID (static levels)
    input wire logic force_single_ended_strap_in,
    input wire logic delayed_spinup_strap_in,
    input wire logic await_start_command_strap_in,
    input wire logic write_protect_strap_in,
    input wire logic parity_disable_strap_in,
    input wire logic [OSS_ID_W-1:0] scsi_id_in,
    // Bus side
    input wire logic differential_sense_line_in,
    input wire logic start_unit_cmd_in,
    input wire logic parity_error_in,
    input wire logic media_write_req_in,
    // Spindle and option outputs
    output logic spindle_start_out,
    output logic write_protect_out,
    output logic write_allow_out,
    output logic parity_check_enable_out,
    output logic parity_error_report_out,
    output logic single_ended_mode_out,
    output logic config_valid_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    oss_straps_s straps;       // Straps as seen at reset release
    oss_state_e state;         // Spindle sequencing state
    oss_state_e next_state;    // Next sequencing state
    logic [OSS_DSEC_W-1:0] delay_left; // Seconds still to wait
    logic sec_tick;            // One pulse per second while delaying
    logic mode_se;             // Transceiver mode register
    logic force_se_now;        // Force strap: raw at capture, captured afterwards

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture

    // Taken once on the first clock after release; later changes are ignored
    // because the capture state is never re-entered without a reset
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            straps <= OSS_STRAPS_RESET;
        end else if (state == OSS_CAPTURE) begin
            straps.force_single_ended_strap <= force_single_ended_strap_in;
            straps.delayed_spinup_strap <= delayed_spinup_strap_in;
            straps.await_start_command_strap <= await_start_command_strap_in;
            straps.write_protect_strap <= write_protect_strap_in;
            straps.parity_disable_strap <= parity_disable_strap_in;
            straps.scsi_id <= scsi_id_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Spindle sequencing

    // Choose the path after capture from the freshly sampled straps
    always_comb begin
        next_state = state;
        case (state)
            OSS_CAPTURE: begin
                if (await_start_command_strap_in) begin
                    next_state = OSS_WAIT_CMD;
                end else if (delayed_spinup_strap_in && scsi_id_in != '0) begin
                    next_state = OSS_DELAY;
                end else begin
                    next_state = OSS_RUN;
                end
            end
            OSS_WAIT_CMD: begin
                if (start_unit_cmd_in) begin
                    next_state = OSS_RUN;
                end
            end
            OSS_DELAY: begin
                // Last second expiring ends the wait
                if (sec_tick && delay_left == OSS_DSEC_W'(1)) begin
                    next_state = OSS_RUN;
                end
            end
            OSS_RUN: begin
                next_state = OSS_RUN;
            end
            default: begin
                next_state = OSS_CAPTURE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= OSS_CAPTURE;
        end else begin
            state <= next_state;
        end
    end

    // Delay in seconds: ID times the step, loaded at capture
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            delay_left <= OSS_DSEC_ZERO;
        end else if (state == OSS_CAPTURE) begin
            delay_left <= OSS_DSEC_W'(scsi_id_in * OSS_STEP);
        end else if (state == OSS_DELAY && sec_tick) begin
            delay_left <= delay_left - 1'b1;
        end
    end

    // Seconds base; only runs during the delay so it restarts cleanly
    oss_sec_tick u_sec_tick (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .run_in(state == OSS_DELAY),
        .tick_out(sec_tick)
    );

    // Spindle run request is registered from the next-state decode
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            spindle_start_out <= 1'b0;
        end else begin
            spindle_start_out <= (next_state == OSS_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Options

    // At the capture edge the raw strap decides, so a forced drive never
    // shows differential mode for the one cycle before its straps settle
    assign force_se_now = (state == OSS_CAPTURE) ? force_single_ended_strap_in :
        straps.force_single_ended_strap;

    // Transceiver mode; sense line is live but the force strap wins
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_se <= 1'b1;
        end else if (force_se_now) begin
            mode_se <= 1'b1;
        end else begin
            mode_se <= differential_sense_line_in;
        end
    end

    // Valid from the first edge after release; the capture state never returns
    assign config_valid_out = (state != OSS_CAPTURE);
    assign single_ended_mode_out = mode_se;
    // Protected until capture so no write slips through at power-up
    assign write_protect_out = straps.write_protect_strap || !config_valid_out;
    assign write_allow_out = media_write_req_in && !write_protect_out;
    // Parity gating follows the captured strap only, never the live pin
    assign parity_check_enable_out = !straps.parity_disable_strap;
    assign parity_error_report_out = parity_error_in && parity_check_enable_out;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_straps_held: assert property (@(posedge clk_in) disable iff (!resetn_in)
        config_valid_out && $past(config_valid_out) |-> $stable(straps))
        else $error("straps changed after capture");
    a_wait_no_spin: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_WAIT_CMD && !start_unit_cmd_in |=> !spindle_start_out)
        else $error("spindle started without command");
    a_cmd_spin: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_WAIT_CMD && start_unit_cmd_in |=> spindle_start_out)
        else $error("command did not start spindle");
    a_both_straps: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_CAPTURE && await_start_command_strap_in && delayed_spinup_strap_in
        |=> state == OSS_WAIT_CMD)
        else $error("delay not overridden");
    a_immediate_spin: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_CAPTURE && !await_start_command_strap_in && !delayed_spinup_strap_in
        |=> spindle_start_out)
        else $error("no immediate spin up");
    a_delay_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_CAPTURE |=> delay_left == OSS_DSEC_W'(straps.scsi_id * OSS_STEP))
        else $error("wrong start delay");
    a_delay_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_DELAY && delay_left != OSS_DSEC_ZERO |-> !spindle_start_out)
        else $error("spindle early in delay");
    a_wp_block: assert property (@(posedge clk_in) disable iff (!resetn_in)
        straps.write_protect_strap |-> !write_allow_out)
        else $error("write passed while protected");
    a_parity_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
        straps.parity_disable_strap |-> !parity_error_report_out && !parity_check_enable_out)
        else $error("parity reported while disabled");
    a_parity_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
        config_valid_out && !straps.parity_disable_strap && parity_error_in
        |-> parity_error_report_out)
        else $error("parity error not reported");
    a_force_se: assert property (@(posedge clk_in) disable iff (!resetn_in)
        config_valid_out && straps.force_single_ended_strap |-> single_ended_mode_out)
        else $error("force single ended ignored");
    a_sense_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
        config_valid_out && !straps.force_single_ended_strap
        |=> single_ended_mode_out == $past(differential_sense_line_in))
        else $error("mode does not follow sense line");
    a_await_no_delay: assert property (@(posedge clk_in) disable iff (!resetn_in)
        config_valid_out && straps.await_start_command_strap |-> state != OSS_DELAY)
        else $error("delay taken with await strap");
    a_no_strap_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
        config_valid_out && !straps.await_start_command_strap && !straps.delayed_spinup_strap
        |-> spindle_start_out)
        else $error("spindle idle without straps");
    a_id_zero_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
        config_valid_out && !straps.await_start_command_strap && straps.scsi_id == '0
        |-> spindle_start_out)
        else $error("ID zero start was delayed");

    c_wait_cmd: cover property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_WAIT_CMD ##1 state == OSS_RUN);
    c_delay_done: cover property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_DELAY ##1 state == OSS_RUN);
    c_immediate: cover property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_CAPTURE ##1 state == OSS_RUN);
    c_wait_entered: cover property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_CAPTURE ##1 state == OSS_WAIT_CMD);
    c_delay_entered: cover property (@(posedge clk_in) disable iff (!resetn_in)
        state == OSS_CAPTURE ##1 state == OSS_DELAY);

endmodule : oss_startup_ctrl
`default_nettype wire

//--- sim/oss_host_model.sv
// Host initiator and bus-side level model for the strap startup bench
`timescale 1ns/1ps
`default_nettype none
module oss_host_model (
    // Clock
    input wire logic clk_in,
    // Bus-side levels seen by the drive
    output logic start_unit_cmd_out,
    output logic parity_error_out,
    output logic media_write_req_out,
    output logic differential_sense_line_out
);
    // Quiet bus at time zero
    initial begin
        start_unit_cmd_out = 1'h0;
        parity_error_out = 1'h0;
        media_write_req_out = 1'h0;
        differential_sense_line_out = 1'h0;
    end

    // One-cycle Start Unit pulse, launched off the sampling edge
    task automatic send_start();
        @(negedge clk_in);
        start_unit_cmd_out = 1'h1;
        @(negedge clk_in);
        start_unit_cmd_out = 1'h0;
    endtask : send_start

    // Parity error, write request and sense levels, changed on a falling edge
    task automatic set_bus(input logic perr, input logic wreq, input logic sns);
        @(negedge clk_in);
        parity_error_out = perr;
        media_write_req_out = wreq;
        differential_sense_line_out = sns;
    endtask : set_bus
endmodule : oss_host_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for strap capture and spindle start sequencing
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import oss_pkg::*;
    // One table row: straps, sense level and the outputs they should give
    typedef struct packed {
        oss_straps_s straps;
        logic sense;
        logic spin_early;
        logic spin_cmd;
        logic se;
    } oss_row_s;
    logic clk_in, resetn_in, start_cmd, perr, wreq, sense;
    logic spin, wp, wallow, pce, prep, se, cfg;
    oss_straps_s straps;
    int bad_count = 0;
    int n_checks = 0;
    // Delayed rows use ID above zero except row 2 (ID 0): a real delay is far beyond this run
    oss_row_s rows [5] = '{
        '{'{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'h0}, 1'h0, 1'h1, 1'h1, 1'h0},
        '{'{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 4'h2}, 1'h0, 1'h0, 1'h1, 1'h0},
        '{'{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0}, 1'h0, 1'h1, 1'h1, 1'h1},
        '{'{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 4'h3}, 1'h1, 1'h0, 1'h0, 1'h1},
        '{'{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 4'h5}, 1'h0, 1'h0, 1'h1, 1'h0}};

    ////////////////////////////////////////////////////////////////////////
    // Design and host model
    oss_startup_ctrl u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .force_single_ended_strap_in(straps.force_single_ended_strap),
        .delayed_spinup_strap_in(straps.delayed_spinup_strap),
        .await_start_command_strap_in(straps.await_start_command_strap),
        .write_protect_strap_in(straps.write_protect_strap),
        .parity_disable_strap_in(straps.parity_disable_strap),
        .scsi_id_in(straps.scsi_id), .differential_sense_line_in(sense),
        .start_unit_cmd_in(start_cmd), .parity_error_in(perr),
        .media_write_req_in(wreq), .spindle_start_out(spin),
        .write_protect_out(wp), .write_allow_out(wallow),
        .parity_check_enable_out(pce), .parity_error_report_out(prep),
        .single_ended_mode_out(se), .config_valid_out(cfg));
    oss_host_model u_host (.clk_in(clk_in), .start_unit_cmd_out(start_cmd),
        .parity_error_out(perr), .media_write_req_out(wreq),
        .differential_sense_line_out(sense));

    ////////////////////////////////////////////////////////////////////////
    // Clock: 40 ns period
    initial begin
        clk_in = 1'h0;
        forever #20 clk_in = ~clk_in;
    end

    // Compare one observed bit with its expectation
    task automatic check(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check

    // Counts, verdict and end of run
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // Reset for 3 cycles with new straps, then wait bounded for capture
    task automatic do_reset(input oss_straps_s s);
        int i;
        @(negedge clk_in);
        resetn_in = 1'h0;
        straps = s;
        repeat (3) @(negedge clk_in);
        check(wp, 1'h1, "protect in reset");
        check(spin, 1'h0, "spin in reset");
        check(cfg, 1'h0, "valid in reset");
        resetn_in = 1'h1;
        for (i = 0; i < 10 && cfg !== 1'h1; i++) begin
            @(negedge clk_in);
        end
        if (cfg !== 1'h1) begin
            check(cfg, 1'h1, "capture timeout");
            complete_run();
        end
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: table rows, then strap changes after capture
    initial begin
        resetn_in = 1'h0;
        straps = OSS_STRAPS_RESET;
        foreach (rows[k]) begin
            u_host.set_bus(1'h1, 1'h1, rows[k].sense);
            do_reset(rows[k].straps);
            repeat (20) @(negedge clk_in);
            check(spin, rows[k].spin_early, "spindle at power-up");
            check(wp, rows[k].straps.write_protect_strap, "protect");
            check(wallow, !rows[k].straps.write_protect_strap, "write allow");
            check(pce, !rows[k].straps.parity_disable_strap, "parity check");
            check(prep, !rows[k].straps.parity_disable_strap, "parity report");
            check(se, rows[k].se, "transceiver mode");
            // Quiet bus and a flipped sense level: gating drops, mode tracks live
            u_host.set_bus(1'h0, 1'h0, !rows[k].sense);
            repeat (2) @(negedge clk_in);
            check(prep, 1'h0, "quiet parity");
            check(wallow, 1'h0, "no write request");
            check(se, rows[k].straps.force_single_ended_strap | !rows[k].sense,
                "live sense");
            u_host.send_start();
            repeat (2) @(negedge clk_in);
            check(spin, rows[k].spin_cmd, "spindle after command");
            $display("row %0d done", k);
        end
        // Straps moved after capture must change nothing until reset
        u_host.set_bus(1'h1, 1'h1, 1'h0);
        do_reset(rows[1].straps);
        straps = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4'h0};
        repeat (10) @(negedge clk_in);
        check(spin, 1'h0, "late strap spin");
        check(wp, 1'h0, "late strap protect");
        check(pce, 1'h0, "late strap parity");
        check(se, 1'h0, "late strap mode");
        u_host.send_start();
        repeat (2) @(negedge clk_in);
        check(spin, 1'h1, "captured await kept");
        $display("late strap test done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
